/* pkg/cpu_flags_map.svh */
// Constants for the flag register and stack pointer block.
// Assumes inclusion by the design files only.
`ifndef CPU_FLAGS_MAP_SVH
`define CPU_FLAGS_MAP_SVH

`define FLG_RST      8'he8
`define FLG_FIXED    8'hc0
`define FLG_I1       5
`define FLG_H        4
`define FLG_I0       3
`define FLG_N        2
`define FLG_Z        1
`define FLG_C        0
`define SP_RST       16'h01ff
`define SP_HI        8'h01
`define SP_LO_RST    8'hff
`define INT_BYTES    3'h5
`define CALL_BYTES   3'h2

`endif

/* pkg/cpu_flags_pkg.sv */
// Types shared by the flag register and stack pointer block.
// Assumes the constants header sits beside it.
package cpu_flags_pkg;

  typedef enum logic [3:0] {
    CMD_PUSH       = 4'h0,
    CMD_PUSH_FLAGS = 4'h1,
    CMD_POP        = 4'h2,
    CMD_CALL       = 4'h3,
    CMD_RET        = 4'h4,
    CMD_INT        = 4'h5,
    CMD_HANDLER_RET = 4'h6,
    CMD_STACK_REINIT = 4'h7,
    CMD_LOAD_SP    = 4'h8
  } stk_cmd_e;

  typedef enum logic [2:0] {
    DST_PCL   = 3'h0,
    DST_PCH   = 3'h1,
    DST_X     = 3'h2,
    DST_A     = 3'h3,
    DST_FLAGS = 3'h4
  } ctx_dst_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PUSH = 3'b010,
    ST_POP  = 3'b100
  } seq_state_e;

endpackage : cpu_flags_pkg

/* hdl/stack_ptr_reg.sv */
// Stack pointer with fixed upper byte and wrapping low byte.
// Assumes one clock, synchronous active-low reset, one-hot controls.
`timescale 1ns/10ps
`include "cpu_flags_map.svh"

module stack_ptr_reg (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        reinit,
  input  wire logic        load,
  input  wire logic [7:0]  load_val,
  input  wire logic        dec,
  input  wire logic        inc,
  output logic      [15:0] stack_pointer
);

  logic [7:0] sp_lo_q;

  always_ff @(posedge mclk) begin
    if (!rst_n || reinit) begin
      sp_lo_q <= `SP_LO_RST;
    end else if (load) begin
      sp_lo_q <= load_val;
    end else if (dec) begin
      sp_lo_q <= sp_lo_q - 8'h01;
    end else if (inc) begin
      sp_lo_q <= sp_lo_q + 8'h01;
    end
  end

  assign stack_pointer = {`SP_HI, sp_lo_q};

  AST_SP_HI_FIXED: assert property (
    @(posedge mclk) disable iff (!rst_n)
    stack_pointer[15:8] == `SP_HI)
    else $error("Stack pointer upper byte changed");

  AST_SP_REINIT: assert property (
    @(posedge mclk) disable iff (!rst_n)
    reinit |=> stack_pointer == `SP_RST)
    else $error("Stack reinit did not restore top address");

  AST_SP_WRAP: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (dec && !reinit && !load && sp_lo_q == 8'h00) |=> sp_lo_q == 8'hff)
    else $error("Stack pointer did not wrap at lower limit");

endmodule : stack_ptr_reg

/* hdl/cpu_flags_sp.sv */
// Flag register, stack pointer and context save/restore sequencer.
// Assumes asynchronous-read stack memory outside and a datapath
// that issues commands only while busy is low.
`timescale 1ns/10ps
`include "cpu_flags_map.svh"

module cpu_flags_sp (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Result flag updates
  input  wire logic        res_valid,
  input  wire logic [7:0]  res_data,
  input  wire logic        add_valid,
  input  wire logic [7:0]  add_op_a,
  input  wire logic [7:0]  add_op_b,
  input  wire logic        add_cin,
  input  wire logic        carry_valid,
  input  wire logic        carry_val,
  input  wire logic        force_overflow_flag_instr,
  input  wire logic        drop_overflow_flag_instr,
  input  wire logic        flag_bit_wr,
  input  wire logic [2:0]  flag_bit_idx,
  input  wire logic        flag_bit_val,
  // Mask instructions
  input  wire logic        interrupt_unmask_instr,
  input  wire logic        interrupt_block_instr,
  input  wire logic        halt_instr,
  input  wire logic        wait_for_event_instr,
  input  wire logic [1:0]  int_prio,
  // Stack commands
  input  wire logic        cmd_valid,
  input  cpu_flags_pkg::stk_cmd_e cmd,
  input  wire logic [15:0] pc_in,
  input  wire logic [7:0]  x_in,
  input  wire logic [7:0]  acc_in,
  input  wire logic [7:0]  cmd_data,
  input  cpu_flags_pkg::ctx_dst_e pop_dst,
  input  wire logic [7:0]  mem_rdata,
  // Outputs
  output logic      [7:0]  flag_register,
  output logic      [15:0] stack_pointer,
  output logic      [1:0]  prio_level_q,
  output logic             ints_masked_q,
  output logic             busy_q,
  output logic      [15:0] stk_addr_q,
  output logic             stk_we_q,
  output logic             stk_re_q,
  output logic      [7:0]  stk_wdata_q,
  output logic             rest_valid_q,
  output cpu_flags_pkg::ctx_dst_e rest_dst_q,
  output logic      [7:0]  rest_data_q
);

  //////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic half_carry(input logic [3:0] a,
                                      input logic [3:0] b,
                                      input logic       ci);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b} + {4'h0, ci};
    return s[4];
  endfunction : half_carry

  // Level from upper, lower mask bits
  function automatic logic [1:0] prio_level(input logic i1,
                                            input logic i0);
    unique case ({i1, i0})
      2'b10:   return 2'd0;
      2'b01:   return 2'd1;
      2'b00:   return 2'd2;
      default: return 2'd3;
    endcase
  endfunction : prio_level

  //////////////////////////////////////////////////////////////////
  // Declarations

  cpu_flags_pkg::seq_state_e state_q;
  cpu_flags_pkg::ctx_dst_e   dst_q [0:4];
  cpu_flags_pkg::ctx_dst_e   rd_dst_q;
  logic [7:0]  byte_q [0:4];
  logic [2:0]  idx_q;
  logic [2:0]  cnt_q;
  logic        int_seq_q;
  logic [1:0]  int_prio_q;
  logic [7:0]  flag_q;
  logic [7:0]  flag_d;
  logic        cmd_go;
  logic        last;
  logic        int_done;
  logic        flags_restore;
  logic        sp_dec;
  logic        sp_inc;
  logic        sp_reinit;
  logic        sp_load;
  logic        h_calc;
  logic        res_msb;
  logic        res_zero;
  logic [7:0]  pcl_in;

  assign cmd_go    = cmd_valid && state_q == cpu_flags_pkg::ST_IDLE;
  assign last      = idx_q == cnt_q - 3'h1;
  assign int_done  = state_q == cpu_flags_pkg::ST_PUSH && last && int_seq_q;
  assign flags_restore = stk_re_q && rd_dst_q == cpu_flags_pkg::DST_FLAGS;
  assign sp_dec    = state_q == cpu_flags_pkg::ST_PUSH;
  assign sp_inc    = state_q == cpu_flags_pkg::ST_POP;
  assign sp_reinit = cmd_go && cmd == cpu_flags_pkg::CMD_STACK_REINIT;
  assign sp_load   = cmd_go && cmd == cpu_flags_pkg::CMD_LOAD_SP;
  assign h_calc    = half_carry(add_op_a[3:0], add_op_b[3:0], add_cin);
  assign res_msb   = res_data[7];
  assign res_zero  = res_data == 8'h00;
  assign pcl_in    = pc_in[7:0];

  //////////////////////////////////////////////////////////////////
  // Stack pointer

  stack_ptr_reg u_sp (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .reinit        (sp_reinit),
    .load          (sp_load),
    .load_val      (cmd_data),
    .dec           (sp_dec),
    .inc           (sp_inc),
    .stack_pointer (stack_pointer)
  );

  //////////////////////////////////////////////////////////////////
  // Context sequencer

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_q    <= cpu_flags_pkg::ST_IDLE;
      idx_q      <= 3'h0;
      cnt_q      <= 3'h1;
      int_seq_q  <= 1'b0;
      int_prio_q <= 2'b11;
      busy_q     <= 1'b0;
    end else begin
      unique case (state_q)
        cpu_flags_pkg::ST_IDLE: begin
          idx_q     <= 3'h0;
          int_seq_q <= 1'b0;
          if (cmd_valid) begin
            unique case (cmd)
              cpu_flags_pkg::CMD_PUSH,
              cpu_flags_pkg::CMD_PUSH_FLAGS: begin
                cnt_q   <= 3'h1;
                state_q <= cpu_flags_pkg::ST_PUSH;
                busy_q  <= 1'b1;
              end
              cpu_flags_pkg::CMD_CALL: begin
                cnt_q   <= `CALL_BYTES;
                state_q <= cpu_flags_pkg::ST_PUSH;
                busy_q  <= 1'b1;
              end
              cpu_flags_pkg::CMD_INT: begin
                cnt_q      <= `INT_BYTES;
                int_seq_q  <= 1'b1;
                int_prio_q <= int_prio;
                state_q    <= cpu_flags_pkg::ST_PUSH;
                busy_q     <= 1'b1;
              end
              cpu_flags_pkg::CMD_POP: begin
                cnt_q   <= 3'h1;
                state_q <= cpu_flags_pkg::ST_POP;
                busy_q  <= 1'b1;
              end
              cpu_flags_pkg::CMD_RET: begin
                cnt_q   <= `CALL_BYTES;
                state_q <= cpu_flags_pkg::ST_POP;
                busy_q  <= 1'b1;
              end
              cpu_flags_pkg::CMD_HANDLER_RET: begin
                cnt_q   <= `INT_BYTES;
                state_q <= cpu_flags_pkg::ST_POP;
                busy_q  <= 1'b1;
              end
              default: begin
              end
            endcase
          end
        end
        cpu_flags_pkg::ST_PUSH,
        cpu_flags_pkg::ST_POP: begin
          idx_q <= idx_q + 3'h1;
          if (last) begin
            state_q <= cpu_flags_pkg::ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Byte and destination lists, loaded on command accept
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      for (int i = 0; i < 5; i++) begin
        byte_q[i] <= 8'h00;
        dst_q[i]  <= cpu_flags_pkg::DST_PCL;
      end
    end else if (cmd_go) begin
      unique case (cmd)
        cpu_flags_pkg::CMD_PUSH:       byte_q[0] <= cmd_data;
        cpu_flags_pkg::CMD_PUSH_FLAGS: byte_q[0] <= flag_q;
        cpu_flags_pkg::CMD_CALL: begin
          byte_q[0] <= pc_in[7:0];
          byte_q[1] <= pc_in[15:8];
        end
        cpu_flags_pkg::CMD_INT: begin
          // Second index register has no path here
          byte_q[0] <= pc_in[7:0];
          byte_q[1] <= pc_in[15:8];
          byte_q[2] <= x_in;
          byte_q[3] <= acc_in;
          byte_q[4] <= flag_q;
        end
        cpu_flags_pkg::CMD_POP: dst_q[0] <= pop_dst;
        cpu_flags_pkg::CMD_RET: begin
          dst_q[0] <= cpu_flags_pkg::DST_PCH;
          dst_q[1] <= cpu_flags_pkg::DST_PCL;
        end
        cpu_flags_pkg::CMD_HANDLER_RET: begin
          dst_q[0] <= cpu_flags_pkg::DST_FLAGS;
          dst_q[1] <= cpu_flags_pkg::DST_A;
          dst_q[2] <= cpu_flags_pkg::DST_X;
          dst_q[3] <= cpu_flags_pkg::DST_PCH;
          dst_q[4] <= cpu_flags_pkg::DST_PCL;
        end
        default: begin
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////
  // Stack memory port

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stk_addr_q  <= `SP_RST;
      stk_we_q    <= 1'b0;
      stk_re_q    <= 1'b0;
      stk_wdata_q <= 8'h00;
      rd_dst_q    <= cpu_flags_pkg::DST_PCL;
    end else begin
      stk_we_q <= sp_dec;
      stk_re_q <= sp_inc;
      if (sp_dec) begin
        stk_addr_q  <= stack_pointer;
        stk_wdata_q <= byte_q[idx_q];
      end else if (sp_inc) begin
        stk_addr_q <= {`SP_HI, stack_pointer[7:0] + 8'h01};
        rd_dst_q   <= dst_q[idx_q];
      end
    end
  end

  // Restored bytes to the datapath
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rest_valid_q <= 1'b0;
      rest_dst_q   <= cpu_flags_pkg::DST_PCL;
      rest_data_q  <= 8'h00;
    end else begin
      rest_valid_q <= stk_re_q;
      if (stk_re_q) begin
        rest_dst_q  <= rd_dst_q;
        rest_data_q <= mem_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////
  // Flag register

  always_comb begin
    flag_d = flag_q;
    if (res_valid) begin
      flag_d[`FLG_N] = res_data[7];
      flag_d[`FLG_Z] = res_zero;
    end
    if (add_valid) begin
      flag_d[`FLG_H] = h_calc;
    end
    if (carry_valid) begin
      flag_d[`FLG_C] = carry_val;
    end
    if (force_overflow_flag_instr) begin
      flag_d[`FLG_C] = 1'b1;
    end
    if (drop_overflow_flag_instr) begin
      flag_d[`FLG_C] = 1'b0;
    end
    if (interrupt_unmask_instr || halt_instr || wait_for_event_instr) begin
      flag_d[`FLG_I1] = 1'b1;
      flag_d[`FLG_I0] = 1'b0;
    end
    if (interrupt_block_instr) begin
      flag_d[`FLG_I1] = 1'b1;
      flag_d[`FLG_I0] = 1'b1;
    end
    if (flag_bit_wr) begin
      flag_d[flag_bit_idx] = flag_bit_val;
    end
    if (int_done) begin
      flag_d[`FLG_I1] = int_prio_q[1];
      flag_d[`FLG_I0] = int_prio_q[0];
    end
    if (flags_restore) begin
      flag_d = mem_rdata;
    end
    flag_d = flag_d | `FLG_FIXED;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      flag_q        <= `FLG_RST;
      prio_level_q  <= 2'd3;
      ints_masked_q <= 1'b1;
    end else begin
      flag_q        <= flag_d;
      prio_level_q  <= prio_level(flag_d[`FLG_I1], flag_d[`FLG_I0]);
      ints_masked_q <= flag_d[`FLG_I1] && flag_d[`FLG_I0];
    end
  end

  assign flag_register = flag_q;

  //////////////////////////////////////////////////////////////////
  // Checks

  AST_FLAG_FIXED: assert property (
    @(posedge mclk) disable iff (!rst_n)
    flag_register[7:6] == 2'b11)
    else $error("Fixed flag bits not one");

  AST_HALF_CARRY: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (add_valid && !flag_bit_wr && !flags_restore)
      |=> flag_register[`FLG_H] == $past(h_calc))
    else $error("Half carry wrong after add");

  AST_SIGN_ZERO: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (res_valid && !flag_bit_wr && !flags_restore)
      |=> flag_register[`FLG_N] == $past(res_msb)
       && flag_register[`FLG_Z] == $past(res_zero))
    else $error("Sign or zero flag wrong");

  AST_CARRY_FORCE: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (force_overflow_flag_instr && !drop_overflow_flag_instr
     && !flag_bit_wr && !flags_restore) |=> flag_register[`FLG_C])
    else $error("Carry not forced high");

  AST_LEVEL_DECODE: assert property (
    @(posedge mclk) disable iff (!rst_n)
    prio_level_q == prio_level(flag_register[`FLG_I1], flag_register[`FLG_I0])
    && ints_masked_q == (prio_level_q == 2'd3))
    else $error("Priority level decode mismatch");

  AST_INT_FIVE_BYTES: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (cmd_go && cmd == cpu_flags_pkg::CMD_INT)
      |=> ##1 stk_we_q [*5] ##1 !stk_we_q)
    else $error("Interrupt entry did not write five bytes");

  AST_PCL_FIRST: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (cmd_go && cmd == cpu_flags_pkg::CMD_INT)
      |-> ##2 stk_wdata_q == $past(pcl_in, 2)
       && stk_addr_q == $past(stack_pointer, 2))
    else $error("Low return address not first at pointer");

  AST_PUSH_DEC: assert property (
    @(posedge mclk) disable iff (!rst_n)
    stk_we_q |-> stack_pointer[7:0] == stk_addr_q[7:0] - 8'h01)
    else $error("Pointer not decremented after push");

  AST_PRIO_LOAD: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (cmd_go && cmd == cpu_flags_pkg::CMD_INT)
      |-> ##6 {flag_register[`FLG_I1], flag_register[`FLG_I0]}
              == $past(int_prio, 6))
    else $error("Mask bits not loaded at interrupt entry");

endmodule : cpu_flags_sp

/* tb/stack_ram_model.sv */
// Stack RAM behind the flopped stack port, 256 bytes, asynchronous read.
// Assumes the upper address byte is fixed, so only the low byte selects.
`timescale 1ns/10ps

module stack_ram_model (
  input  wire logic        mclk,
  input  wire logic [15:0] stk_addr_q,
  input  wire logic        stk_we_q,
  input  wire logic        stk_re_q,
  input  wire logic [7:0]  stk_wdata_q,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [256];

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h5a;
    end
  end

  // Write on the edge that samples the write strobe
  always @(posedge mclk) begin
    if (stk_we_q === 1'b1) begin
      mem[stk_addr_q[7:0]] <= stk_wdata_q;
    end
  end

  // Data valid only while read strobe high, inverted junk otherwise
  assign mem_rdata = (stk_re_q === 1'b1) ? mem[stk_addr_q[7:0]] : ~mem[stk_addr_q[7:0]];
endmodule : stack_ram_model

/* tb/tb.sv */
// Self-checking bench for the flag register and stack pointer block.
// Assumes the stack RAM model and the design files are compiled first.
`timescale 1ns/10ps

module tb;
  logic mclk = 1'b0, rst_n = 1'b0, res_valid = 1'b0, add_valid = 1'b0, add_cin = 1'b0;
  logic carry_valid = 1'b0, carry_val = 1'b0, force_c = 1'b0, drop_c = 1'b0;
  logic flag_bit_wr = 1'b0, flag_bit_val = 1'b0, unmask = 1'b0, block = 1'b0;
  logic halt_instr = 1'b0, wait_instr = 1'b0, cmd_valid = 1'b0;
  logic [7:0] res_data = 8'h00, add_op_a = 8'h00, add_op_b = 8'h00, x_in = 8'h00;
  logic [7:0] acc_in = 8'h00, cmd_data = 8'h00, mem_rdata, flag_register, stk_wdata_q, rest_data_q;
  logic [2:0] flag_bit_idx = 3'h0;
  logic [1:0] int_prio = 2'h0, prio_level_q;
  logic [15:0] pc_in = 16'h0000, stack_pointer, stk_addr_q;
  logic ints_masked_q, busy_q, stk_we_q, stk_re_q, rest_valid_q;
  cpu_flags_pkg::stk_cmd_e cmd = cpu_flags_pkg::CMD_PUSH;
  cpu_flags_pkg::ctx_dst_e pop_dst = cpu_flags_pkg::DST_A, rest_dst_q;
  int fail_count = 0, checks_done = 0;
  logic [31:0] lfsr = 32'hee98e992;
  logic [7:0] sp_e, f_e, d_e [5];
  logic [15:0] wa [$];
  logic [7:0] wd [$], rv [$];
  logic [2:0] rd [$];

  always #2 mclk = ~mclk;

  cpu_flags_sp dut (.mclk(mclk), .rst_n(rst_n), .res_valid(res_valid), .res_data(res_data),
    .add_valid(add_valid), .add_op_a(add_op_a), .add_op_b(add_op_b), .add_cin(add_cin),
    .carry_valid(carry_valid), .carry_val(carry_val), .force_overflow_flag_instr(force_c),
    .drop_overflow_flag_instr(drop_c), .flag_bit_wr(flag_bit_wr), .flag_bit_idx(flag_bit_idx),
    .flag_bit_val(flag_bit_val), .interrupt_unmask_instr(unmask), .interrupt_block_instr(block),
    .halt_instr(halt_instr), .wait_for_event_instr(wait_instr), .int_prio(int_prio),
    .cmd_valid(cmd_valid), .cmd(cmd), .pc_in(pc_in), .x_in(x_in), .acc_in(acc_in),
    .cmd_data(cmd_data), .pop_dst(pop_dst), .mem_rdata(mem_rdata),
    .flag_register(flag_register), .stack_pointer(stack_pointer), .prio_level_q(prio_level_q),
    .ints_masked_q(ints_masked_q), .busy_q(busy_q), .stk_addr_q(stk_addr_q),
    .stk_we_q(stk_we_q), .stk_re_q(stk_re_q), .stk_wdata_q(stk_wdata_q),
    .rest_valid_q(rest_valid_q), .rest_dst_q(rest_dst_q), .rest_data_q(rest_data_q));

  stack_ram_model ram (.mclk(mclk), .stk_addr_q(stk_addr_q), .stk_we_q(stk_we_q),
    .stk_re_q(stk_re_q), .stk_wdata_q(stk_wdata_q), .mem_rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Stack port and restore monitor
  always @(negedge mclk) begin
    if (stk_we_q === 1'b1) begin
      wa.push_back(stk_addr_q);
      wd.push_back(stk_wdata_q);
    end
    if (rest_valid_q === 1'b1) begin
      rd.push_back(rest_dst_q);
      rv.push_back(rest_data_q);
    end
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction : nxt

  function automatic logic [1:0] lvl(input logic i1, input logic i0);
    lvl = {~(i1 ^ i0), i0};
  endfunction : lvl

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  // Command issue with optional poke while busy, bounded completion wait
  task automatic run(input cpu_flags_pkg::stk_cmd_e c, input bit poke);
    int i;
    wa.delete(); wd.delete(); rd.delete(); rv.delete();
    cmd = c;
    cmd_valid = 1'b1;
    @(negedge mclk);
    if (poke) begin
      cmd = cpu_flags_pkg::CMD_PUSH;
      @(negedge mclk);
    end
    cmd_valid = 1'b0;
    for (i = 0; i < 20 && busy_q !== 1'b0; i++) @(negedge mclk);
    if (i == 20) begin
      fail_count++;
      finish_test();
    end
    repeat (2) @(negedge mclk);
  endtask : run

  initial begin
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    chk(flag_register, 16'h00e8);
    chk(stack_pointer, 16'h01ff);
    chk({prio_level_q, ints_masked_q}, 16'h0007);
    // Random and corner flag updates
    for (int i = 0; i < 24; i++) begin
      lfsr = nxt(lfsr);
      res_data = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : lfsr[7:0];
      add_op_a = (i == 0) ? 8'h0f : lfsr[15:8];
      add_op_b = (i == 0) ? 8'h01 : lfsr[23:16];
      add_cin = (i == 0) ? 1'b0 : lfsr[24];
      carry_val = lfsr[25];
      {res_valid, add_valid, carry_valid} = 3'b111;
      @(negedge mclk);
      {res_valid, add_valid, carry_valid} = 3'b000;
      chk(flag_register[4], ({1'b0, add_op_a[3:0]} + add_op_b[3:0] + add_cin) > 5'h0f);
      chk(flag_register[2], res_data[7]);
      chk(flag_register[1], res_data == 8'h00);
      chk(flag_register[0], carry_val);
    end
    force_c = 1'b1;
    @(negedge mclk);
    force_c = 1'b0;
    chk(flag_register[0], 1'b1);
    drop_c = 1'b1;
    @(negedge mclk);
    drop_c = 1'b0;
    chk(flag_register[0], 1'b0);
    {flag_bit_wr, flag_bit_idx, flag_bit_val} = 5'b1_111_0;
    @(negedge mclk);
    {flag_bit_idx, flag_bit_val} = 4'b001_1;
    @(negedge mclk);
    flag_bit_wr = 1'b0;
    chk({flag_register[7:6], flag_register[1]}, 16'h0007);
    // Mask instruction table
    for (int j = 0; j < 6; j++) begin
      block = (j % 2 == 0);
      unmask = (j == 1);
      halt_instr = (j == 3);
      wait_instr = (j == 5);
      @(negedge mclk);
      {block, unmask, halt_instr, wait_instr} = 4'h0;
      f_e = (j % 2 == 0) ? 8'h28 : 8'h20;
      chk(flag_register & 8'h28, f_e);
      chk(prio_level_q, lvl(f_e[5], f_e[3]));
      chk(ints_masked_q, j % 2 == 0);
    end
    // Push byte and flags, pop both back
    lfsr = nxt(lfsr);
    cmd_data = lfsr[7:0];
    f_e = flag_register;
    run(cpu_flags_pkg::CMD_PUSH, 0);
    run(cpu_flags_pkg::CMD_PUSH_FLAGS, 0);
    chk(stack_pointer, 16'h01fd);
    chk(wd[0], f_e);
    chk(wa[0], 16'h01fe);
    pop_dst = cpu_flags_pkg::DST_FLAGS;
    run(cpu_flags_pkg::CMD_POP, 0);
    chk(flag_register, f_e);
    pop_dst = cpu_flags_pkg::DST_A;
    run(cpu_flags_pkg::CMD_POP, 0);
    chk({rd[0], rv[0]}, {cpu_flags_pkg::DST_A, cmd_data});
    chk(stack_pointer, 16'h01ff);
    // Call and return
    pc_in = lfsr[31:16];
    run(cpu_flags_pkg::CMD_CALL, 0);
    chk(16'(wa.size()), 16'd2);
    chk(stack_pointer, 16'h01fd);
    chk({wa[0][7:0], wd[0]}, {8'hff, pc_in[7:0]});
    chk({wa[1][7:0], wd[1]}, {8'hfe, pc_in[15:8]});
    run(cpu_flags_pkg::CMD_RET, 0);
    chk({rd[0], rv[0]}, {3'h1, pc_in[15:8]});
    chk({rd[1], rv[1]}, {3'h0, pc_in[7:0]});
    chk(stack_pointer, 16'h01ff);
    // Interrupt entry and return at every priority, each one wrapping, first one poked while busy
    cmd_data = 8'h02;
    run(cpu_flags_pkg::CMD_LOAD_SP, 0);
    chk(stack_pointer, 16'h0102);
    for (int p = 0; p < 4; p++) begin
      lfsr = nxt(lfsr);
      {pc_in, x_in, acc_in} = lfsr;
      int_prio = p[1:0];
      sp_e = stack_pointer[7:0];
      f_e = flag_register;
      d_e = '{pc_in[7:0], pc_in[15:8], x_in, acc_in, f_e};
      run(cpu_flags_pkg::CMD_INT, p == 0);
      chk(16'(wa.size()), 16'd5);
      for (int k = 0; k < 5; k++) begin
        chk(wa[k], {8'h01, sp_e - k[7:0]});
        chk(wd[k], d_e[k]);
      end
      chk(stack_pointer, {8'h01, sp_e - 8'h05});
      chk({flag_register[5], flag_register[3]}, int_prio);
      chk(prio_level_q, lvl(int_prio[1], int_prio[0]));
      run(cpu_flags_pkg::CMD_HANDLER_RET, 0);
      for (int k = 0; k < 5; k++) begin
        chk({rd[k], rv[k]}, {3'(4 - k), d_e[4 - k]});
      end
      chk({flag_register, stack_pointer[7:0]}, {f_e, sp_e});
    end
    // Reinit then pop past the top
    run(cpu_flags_pkg::CMD_STACK_REINIT, 0);
    chk(stack_pointer, 16'h01ff);
    run(cpu_flags_pkg::CMD_POP, 0);
    chk(stack_pointer, 16'h0100);
    // Reset while idle, after the last run
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    chk({flag_register, stack_pointer[7:0]}, 16'he8ff);
    chk({prio_level_q, ints_masked_q, busy_q, stk_we_q, stk_re_q, rest_valid_q}, 16'h0070);
    finish_test();
  end
endmodule : tb
